// ---- pkg/tls_pkg.sv ----
// Purpose: Shared constants and types for the torque limit selector
// Assumes: Percent settings in 1% steps; torque in 0.1% of rated torque
// Notes:   Register offsets and field positions live here only
package tls_pkg;

  // Setting range and factory values, percent of rated torque
  localparam logic [9:0]  TLS_LIMIT_MAX      = 10'h320;  // 800 %
  localparam logic [9:0]  TLS_INT_DEFAULT    = 10'h320;  // 800 %
  localparam logic [9:0]  TLS_EXT_DEFAULT    = 10'h064;  // 100 %
  localparam logic [9:0]  TLS_MOTOR_MAX_DEF  = 10'h12C;  // 300 %

  // Register byte offsets
  localparam logic [4:0]  TLS_OFS_FWD_INT    = 5'h00;
  localparam logic [4:0]  TLS_OFS_REV_INT    = 5'h04;
  localparam logic [4:0]  TLS_OFS_FWD_EXT    = 5'h08;
  localparam logic [4:0]  TLS_OFS_REV_EXT    = 5'h0C;
  localparam logic [4:0]  TLS_OFS_STATUS     = 5'h10;
  localparam logic [4:0]  TLS_OFS_IRQ_STAT   = 5'h14;
  localparam logic [4:0]  TLS_OFS_IRQ_MASK   = 5'h18;
  localparam logic [4:0]  TLS_OFS_MOTOR_MAX  = 5'h1C;

  // Status and interrupt bit positions
  localparam int          TLS_BIT_FWD_CLAMP  = 0;
  localparam int          TLS_BIT_REV_CLAMP  = 1;
  localparam int          TLS_BIT_LIMITED    = 2;
  localparam int          TLS_BIT_FWD_REQ    = 3;
  localparam int          TLS_BIT_REV_REQ    = 4;
  localparam int          TLS_IRQ_BITS       = 3;

  // Interrupt event positions
  localparam int          TLS_EVT_LIM_ON     = 0;
  localparam int          TLS_EVT_LIM_OFF    = 1;
  localparam int          TLS_EVT_CFG_CLIP   = 2;

  // Torque reference is signed, in 0.1 % of rated torque
  localparam int          TLS_TRQ_W          = 16;
  localparam logic [3:0]  TLS_PCT_SCALE      = 4'hA;

  // Avalon slave handshake state
  typedef enum logic [0:0] {
    TLS_BUS_IDLE = 1'b0,
    TLS_BUS_DONE = 1'b1
  } tls_bus_state_type;

  // Pair of effective limits in 0.1 % units
  typedef struct packed {
    logic [13:0] fwd;
    logic [13:0] rev;
  } tls_limit_pair_type;

endpackage

// ---- hw/tls_in_sync.sv ----
// Purpose: Combine mapped terminal functions and synchronise them
// Assumes: Terminals are asynchronous pins
// Notes:   First stage is read only by the second stage
module tls_in_sync
  import tls_pkg::*;
#(
  parameter int N = 4
) (
  input  wire logic         ref_clk,
  input  wire logic         rst_b,
  input  wire logic [N-1:0] term_pins,
  input  wire logic [N-1:0] fwd_map,
  input  wire logic [N-1:0] rev_map,
  output logic              fwd_ext_limit_request,
  output logic              rev_ext_limit_request
);

  logic [N-1:0] sync_a;
  logic [N-1:0] sync_b;

  ////////////////////////////////////////////////////////////////////////
  // Two flops per terminal
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_sync
      always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
          sync_a[g] <= 1'b0;
          sync_b[g] <= 1'b0;
        end else begin
          sync_a[g] <= term_pins[g];
          sync_b[g] <= sync_a[g];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // OR of mapped terminals
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      fwd_ext_limit_request <= 1'b0;
      rev_ext_limit_request <= 1'b0;
    end else begin
      fwd_ext_limit_request <= |(sync_b & fwd_map);
      rev_ext_limit_request <= |(sync_b & rev_map);
    end
  end

endmodule

// ---- hw/tls_limit_calc.sv ----
// Purpose: Compute effective forward and reverse limits
// Assumes: Settings already held in 0..800 range
// Notes:   Registered result, one cycle behind its inputs
module tls_limit_calc
  import tls_pkg::*;
(
  input  wire logic               ref_clk,
  input  wire logic               rst_b,
  input  wire logic [9:0]         fwd_int,
  input  wire logic [9:0]         rev_int,
  input  wire logic [9:0]         fwd_ext,
  input  wire logic [9:0]         rev_ext,
  input  wire logic [9:0]         motor_max,
  input  wire logic               fwd_req,
  input  wire logic               rev_req,
  output tls_limit_pair_type      lim
);

  logic [9:0] fwd_sel;
  logic [9:0] rev_sel;
  logic [9:0] fwd_cap;
  logic [9:0] rev_cap;

  ////////////////////////////////////////////////////////////////////////
  // Selection and motor cap
  always_comb begin
    fwd_sel = (fwd_req && fwd_ext < fwd_int) ? fwd_ext : fwd_int;
    rev_sel = (rev_req && rev_ext < rev_int) ? rev_ext : rev_int;
    fwd_cap = (fwd_sel > motor_max) ? motor_max : fwd_sel;
    rev_cap = (rev_sel > motor_max) ? motor_max : rev_sel;
  end

  ////////////////////////////////////////////////////////////////////////
  // percent to 0.1 % units
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      lim <= '0;
    end else begin
      lim.fwd <= 14'(fwd_cap) * 14'(TLS_PCT_SCALE);
      lim.rev <= 14'(rev_cap) * 14'(TLS_PCT_SCALE);
    end
  end

endmodule

// ---- hw/tls_top.sv ----
// Purpose: Torque limit selection with Avalon-MM setting registers
// Assumes: 250 MHz ref_clk; torque reference is synchronous to it
// Notes:   Reference saturates one cycle after the limits settle
//
// Summary of operation
// - Forward and reverse internal limits always apply, 0..800, default 800.
// - Every limit setting is percent of rated torque, one percent per step.
// - A limit above the motor maximum torque is replaced by that maximum.
// - Forward request on: forward limit is smaller of internal and external.
// - Forward request off: forward limit is the forward internal setting.
// - Reverse request on: reverse limit is smaller of internal and external.
// - Reverse request off: reverse limit is the reverse internal setting.
// - External limits accept 0..800, default 100, effective at once.
// - Functions sharing one terminal see the OR of that terminal.
// - Torque limited flag is on while output torque is clamped.
module tls_top
  import tls_pkg::*;
#(
  parameter int N_TERM = 4
) (
  input  wire logic                     ref_clk,
  input  wire logic                     rst_b,
  // Avalon-MM slave
  input  wire logic [4:0]               avs_address,
  input  wire logic                     avs_read,
  input  wire logic                     avs_write,
  input  wire logic [31:0]              avs_writedata,
  input  wire logic [3:0]               avs_byteenable,
  output logic [31:0]                   avs_readdata,
  output logic                          avs_waitrequest,
  // Discrete terminals and their mapping
  input  wire logic [N_TERM-1:0]        term_pins,
  input  wire logic [N_TERM-1:0]        fwd_map,
  input  wire logic [N_TERM-1:0]        rev_map,
  // Torque path
  input  wire logic [TLS_TRQ_W-1:0]     torque_ref,
  output logic [TLS_TRQ_W-1:0]          torque_out,
  output logic                          torque_limited_flag,
  output logic                          irq
);

  logic [9:0]             fwd_internal_torque_limit;
  logic [9:0]             rev_internal_torque_limit;
  logic [9:0]             fwd_external_torque_limit;
  logic [9:0]             rev_external_torque_limit;
  logic [9:0]             motor_max;
  logic                   fwd_ext_limit_request;
  logic                   rev_ext_limit_request;
  tls_limit_pair_type     lim;
  tls_bus_state_type      bus_state;
  logic                   fwd_clamp;
  logic                   rev_clamp;
  logic                   next_fwd_clamp;
  logic                   next_rev_clamp;
  logic [TLS_TRQ_W-1:0]   next_torque;
  logic [TLS_IRQ_BITS-1:0] irq_stat;
  logic [TLS_IRQ_BITS-1:0] irq_mask;
  logic [TLS_IRQ_BITS-1:0] irq_evt;
  logic                   cfg_clip;
  logic                   wr_go;
  logic                   rd_go;
  logic [9:0]             wr_val;
  logic [9:0]             wr_sat;
  logic [31:0]            rd_mux;
  logic signed [TLS_TRQ_W-1:0] ref_s;
  logic signed [TLS_TRQ_W:0]   fwd_s;
  logic signed [TLS_TRQ_W:0]   rev_s;

  ////////////////////////////////////////////////////////////////////////
  // Terminal input path
  tls_in_sync #(
    .N                     (N_TERM)
  ) u_sync (
    .ref_clk               (ref_clk),
    .rst_b                 (rst_b),
    .term_pins             (term_pins),
    .fwd_map               (fwd_map),
    .rev_map               (rev_map),
    .fwd_ext_limit_request (fwd_ext_limit_request),
    .rev_ext_limit_request (rev_ext_limit_request)
  );

  // Effective limit computation
  tls_limit_calc u_calc (
    .ref_clk   (ref_clk),
    .rst_b     (rst_b),
    .fwd_int   (fwd_internal_torque_limit),
    .rev_int   (rev_internal_torque_limit),
    .fwd_ext   (fwd_external_torque_limit),
    .rev_ext   (rev_external_torque_limit),
    .motor_max (motor_max),
    .fwd_req   (fwd_ext_limit_request),
    .rev_req   (rev_ext_limit_request),
    .lim       (lim)
  );

  ////////////////////////////////////////////////////////////////////////
  // Bus handshake: one wait cycle, answer at second edge
  // Writes land on the edge where the master sees waitrequest low
  assign wr_go = avs_write && (bus_state == TLS_BUS_DONE);
  assign rd_go = avs_read && (bus_state == TLS_BUS_IDLE);

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      bus_state       <= TLS_BUS_IDLE;
      avs_waitrequest <= 1'b1;
    end else begin
      case (bus_state)
        TLS_BUS_IDLE: begin
          if (avs_read || avs_write) begin
            bus_state       <= TLS_BUS_DONE;
            avs_waitrequest <= 1'b0;
          end
        end
        TLS_BUS_DONE: begin
          bus_state       <= TLS_BUS_IDLE;
          avs_waitrequest <= 1'b1;
        end
        default: begin
          bus_state       <= TLS_BUS_IDLE;
          avs_waitrequest <= 1'b1;
        end
      endcase
    end
  end

  // Write value clipped to setting range
  assign wr_val   = avs_writedata[9:0];
  assign wr_sat   = (wr_val > TLS_LIMIT_MAX) ? TLS_LIMIT_MAX : wr_val;
  assign cfg_clip = wr_go && avs_byteenable[1] && (wr_val > TLS_LIMIT_MAX)
                    && (avs_address <= TLS_OFS_REV_EXT);

  ////////////////////////////////////////////////////////////////////////
  // limit and motor maximum settings
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      fwd_internal_torque_limit <= TLS_INT_DEFAULT;
      rev_internal_torque_limit <= TLS_INT_DEFAULT;
      fwd_external_torque_limit <= TLS_EXT_DEFAULT;
      rev_external_torque_limit <= TLS_EXT_DEFAULT;
      motor_max                 <= TLS_MOTOR_MAX_DEF;
    end else if (wr_go && avs_byteenable[0] && avs_byteenable[1]) begin
      case (avs_address)
        TLS_OFS_FWD_INT:   fwd_internal_torque_limit <= wr_sat;
        TLS_OFS_REV_INT:   rev_internal_torque_limit <= wr_sat;
        TLS_OFS_FWD_EXT:   fwd_external_torque_limit <= wr_sat;
        TLS_OFS_REV_EXT:   rev_external_torque_limit <= wr_sat;
        TLS_OFS_MOTOR_MAX: motor_max                 <= wr_sat;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read mux, unmapped reads zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (avs_address)
      TLS_OFS_FWD_INT:   rd_mux[9:0] = fwd_internal_torque_limit;
      TLS_OFS_REV_INT:   rd_mux[9:0] = rev_internal_torque_limit;
      TLS_OFS_FWD_EXT:   rd_mux[9:0] = fwd_external_torque_limit;
      TLS_OFS_REV_EXT:   rd_mux[9:0] = rev_external_torque_limit;
      TLS_OFS_MOTOR_MAX: rd_mux[9:0] = motor_max;
      TLS_OFS_STATUS: begin
        rd_mux[TLS_BIT_FWD_CLAMP] = fwd_clamp;
        rd_mux[TLS_BIT_REV_CLAMP] = rev_clamp;
        rd_mux[TLS_BIT_LIMITED]   = torque_limited_flag;
        rd_mux[TLS_BIT_FWD_REQ]   = fwd_ext_limit_request;
        rd_mux[TLS_BIT_REV_REQ]   = rev_ext_limit_request;
      end
      TLS_OFS_IRQ_STAT:  rd_mux[TLS_IRQ_BITS-1:0] = irq_stat;
      TLS_OFS_IRQ_MASK:  rd_mux[TLS_IRQ_BITS-1:0] = irq_mask;
      default: ;
    endcase
  end

  // Read data register
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      avs_readdata <= 32'h0000_0000;
    end else if (rd_go) begin
      avs_readdata <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // saturate reference both ways
  assign ref_s = signed'(torque_ref);
  assign fwd_s = signed'({3'h0, lim.fwd});
  assign rev_s = -signed'({3'h0, lim.rev});

  always_comb begin
    next_fwd_clamp = (TLS_TRQ_W + 1)'(ref_s) > fwd_s;
    next_rev_clamp = (TLS_TRQ_W + 1)'(ref_s) < rev_s;
    if (next_fwd_clamp) begin
      next_torque = fwd_s[TLS_TRQ_W-1:0];
    end else if (next_rev_clamp) begin
      next_torque = rev_s[TLS_TRQ_W-1:0];
    end else begin
      next_torque = torque_ref;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      torque_out          <= '0;
      fwd_clamp           <= 1'b0;
      rev_clamp           <= 1'b0;
      torque_limited_flag <= 1'b0;
    end else begin
      torque_out          <= next_torque;
      fwd_clamp           <= next_fwd_clamp;
      rev_clamp           <= next_rev_clamp;
      torque_limited_flag <= next_fwd_clamp || next_rev_clamp;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt events: limiting starts, stops, limit setting clipped
  always_comb begin
    irq_evt                   = '0;
    irq_evt[TLS_EVT_LIM_ON]   = (next_fwd_clamp || next_rev_clamp)
                                && !torque_limited_flag;
    irq_evt[TLS_EVT_LIM_OFF]  = !(next_fwd_clamp || next_rev_clamp)
                                && torque_limited_flag;
    irq_evt[TLS_EVT_CFG_CLIP] = cfg_clip;
  end

  // Sticky status, write one clears, set wins
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_stat <= '0;
      irq_mask <= '0;
    end else begin
      if (wr_go && avs_byteenable[0] && avs_address == TLS_OFS_IRQ_STAT) begin
        irq_stat <= (irq_stat & ~avs_writedata[TLS_IRQ_BITS-1:0]) | irq_evt;
      end else begin
        irq_stat <= irq_stat | irq_evt;
      end
      if (wr_go && avs_byteenable[0] && avs_address == TLS_OFS_IRQ_MASK) begin
        irq_mask <= avs_writedata[TLS_IRQ_BITS-1:0];
      end
    end
  end

  // Level interrupt output
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat & irq_mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  a_fwd_sat_bound: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $signed(torque_out) <= $signed({1'b0, lim.fwd}) || $past(lim.fwd)
      != lim.fwd)
    else $error("forward output above limit");
  a_flag_tracks: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (next_fwd_clamp || next_rev_clamp) |=> torque_limited_flag)
    else $error("flag missed clamp");
  a_flag_clear: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !(next_fwd_clamp || next_rev_clamp) |=> !torque_limited_flag)
    else $error("flag stuck on");
  a_int_range: assert property (@(posedge ref_clk) disable iff (!rst_b)
    fwd_internal_torque_limit <= TLS_LIMIT_MAX
      && rev_internal_torque_limit <= TLS_LIMIT_MAX)
    else $error("internal limit out of range");
  a_ext_range: assert property (@(posedge ref_clk) disable iff (!rst_b)
    fwd_external_torque_limit <= TLS_LIMIT_MAX
      && rev_external_torque_limit <= TLS_LIMIT_MAX)
    else $error("external limit out of range");
  a_motor_cap: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $stable(motor_max) |=> lim.fwd <= 14'($past(motor_max))
      * 14'(TLS_PCT_SCALE))
    else $error("limit above motor max");
  a_fwd_off_sel: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (!fwd_ext_limit_request && fwd_internal_torque_limit <= motor_max)
      |=> lim.fwd == 14'($past(fwd_internal_torque_limit))
      * 14'(TLS_PCT_SCALE))
    else $error("forward internal not selected");
  a_fwd_on_sel: assert property (@(posedge ref_clk) disable iff (!rst_b)
    fwd_ext_limit_request |=> lim.fwd <= 14'($past(
      fwd_external_torque_limit)) * 14'(TLS_PCT_SCALE))
    else $error("forward external ignored");
  a_rev_on_sel: assert property (@(posedge ref_clk) disable iff (!rst_b)
    rev_ext_limit_request |=> lim.rev <= 14'($past(
      rev_external_torque_limit)) * 14'(TLS_PCT_SCALE))
    else $error("reverse external ignored");
  a_rev_off_sel: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (!rev_ext_limit_request && rev_internal_torque_limit <= motor_max)
      |=> lim.rev == 14'($past(rev_internal_torque_limit))
      * 14'(TLS_PCT_SCALE))
    else $error("reverse internal not selected");
  a_irq_level: assert property (@(posedge ref_clk) disable iff (!rst_b)
    |(irq_stat & irq_mask) |=> irq)
    else $error("interrupt not raised");
  a_irq_quiet: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !(|(irq_stat & irq_mask)) |=> !irq)
    else $error("interrupt without cause");

  // Saturated values, pass-through and reverse motor cap
  a_rev_sat_bound: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $signed(torque_out) >= -$signed({1'b0, $past(lim.rev)}))
    else $error("reverse output below limit");
  a_fwd_at_limit: assert property (@(posedge ref_clk) disable iff (!rst_b)
    fwd_clamp |->
      $signed(torque_out) == $signed({1'b0, $past(lim.fwd)}))
    else $error("forward clamp value wrong");
  a_rev_at_limit: assert property (@(posedge ref_clk) disable iff (!rst_b)
    rev_clamp |->
      $signed(torque_out) == -$signed({1'b0, $past(lim.rev)}))
    else $error("reverse clamp value wrong");
  a_pass_through: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !torque_limited_flag |-> torque_out == $past(torque_ref))
    else $error("unclamped reference altered");
  a_rev_motor_cap: assert property (@(posedge ref_clk) disable iff (!rst_b)
    lim.rev <= 14'($past(motor_max)) * 14'(TLS_PCT_SCALE))
    else $error("reverse limit above motor max");

  // Bus handshake and clipped settings
  a_wait_single: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  a_wait_answer: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered");
  a_clip_sets: assert property (@(posedge ref_clk) disable iff (!rst_b)
    cfg_clip |=> irq_stat[TLS_EVT_CFG_CLIP])
    else $error("clipped setting not flagged");

  c_fwd_clamp: cover property (@(posedge ref_clk) disable iff (!rst_b)
    fwd_clamp && fwd_ext_limit_request);
  c_rev_clamp: cover property (@(posedge ref_clk) disable iff (!rst_b)
    rev_clamp && rev_ext_limit_request);
  c_irq: cover property (@(posedge ref_clk) disable iff (!rst_b) irq);
  c_cfg_clip: cover property (@(posedge ref_clk) disable iff (!rst_b)
    cfg_clip && irq_mask[TLS_EVT_CFG_CLIP]);
  c_both_req: cover property (@(posedge ref_clk) disable iff (!rst_b)
    fwd_ext_limit_request && rev_ext_limit_request);

endmodule

// ---- testbench/tls_host_model.sv ----
// Purpose: Host controller driving the discrete limit request terminals
// Assumes: Terminal 0 forward, 1 reverse, 2 shared with another function
// Notes:   Pins change just after a rising edge, like a registered output
module tls_host_model #(
  parameter int N = 4
) (
  input  wire logic    ref_clk,
  input  wire logic    rst_b,
  input  wire logic    fwd_on,
  input  wire logic    rev_on,
  input  wire logic    aux_on,
  output logic [N-1:0] term_pins
);
  timeunit 1ns;
  timeprecision 1ps;

  //////////////////////////////
  // host drives requests
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      term_pins <= '0;
    end else begin
      term_pins <= N'({aux_on, rev_on, fwd_on});
    end
  end
endmodule

// ---- testbench/tls_top_bench.sv ----
// Purpose: Self-checking bench for the torque limit selector
// Assumes: An irq mask bit set to one lets that status bit through
// Notes:   Driver queues expectations, a monitor pops and compares
module tls_top_bench
  import tls_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  logic                 ref_clk;
  logic                 rst_b;
  logic [4:0]           avs_address;
  logic                 avs_read;
  logic                 avs_write;
  logic [31:0]          avs_writedata;
  logic [31:0]          avs_readdata;
  logic                 avs_waitrequest;
  logic [3:0]           term_pins;
  logic [3:0]           fwd_map;
  logic [3:0]           rev_map;
  logic [TLS_TRQ_W-1:0] torque_ref;
  logic [TLS_TRQ_W-1:0] torque_out;
  logic                 torque_limited_flag;
  logic                 irq;
  logic                 fwd_on;
  logic                 rev_on;
  logic                 aux_on;
  logic                 smp;
  int                   n_fail;
  int                   n_checks;
  int                   seed;
  int                   fi;
  int                   ri;
  int                   fe;
  int                   re;
  int                   mm;
  bit                   fq;
  bit                   rq;
  logic [31:0]          rd_q[$];
  logic [17:0]          tq_q[$];

  tls_top #(.N_TERM(4)) DUT (
    .ref_clk(ref_clk), .rst_b(rst_b), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .term_pins(term_pins), .fwd_map(fwd_map), .rev_map(rev_map),
    .torque_ref(torque_ref), .torque_out(torque_out),
    .torque_limited_flag(torque_limited_flag), .irq(irq));

  tls_host_model #(.N(4)) host (
    .ref_clk(ref_clk), .rst_b(rst_b), .fwd_on(fwd_on), .rev_on(rev_on),
    .aux_on(aux_on), .term_pins(term_pins));

  // Clock, 4 ns period
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  //////////////////////////////
  // Compare and count
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Verdict and end of run
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // One bus access, held until waitrequest is seen low
  task automatic bus(input bit w, input logic [4:0] a, input logic [31:0] d);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= w;
    avs_read      <= !w;
    do begin
      @(posedge ref_clk);
    end while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge ref_clk);
  endtask

  // Read with queued expectation
  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask

  // Setting write, model keeps the clipped value
  task automatic wr(input logic [4:0] a, input int v);
    int c;
    c = (v > 800) ? 800 : v;
    case (a)
      TLS_OFS_FWD_INT:   fi = c;
      TLS_OFS_REV_INT:   ri = c;
      TLS_OFS_FWD_EXT:   fe = c;
      TLS_OFS_REV_EXT:   re = c;
      TLS_OFS_MOTOR_MAX: mm = c;
      default: ;
    endcase
    bus(1'b1, a, 32'(v));
  endtask

  // Requests through the host model, settle through the synchroniser
  task automatic req(input bit f, input bit r);
    fq = f;
    rq = r;
    fwd_on <= f;
    rev_on <= r;
    repeat (8) @(posedge ref_clk);
  endtask

  // Effective limit in 0.1 % units
  function automatic int lim(input int i, input int e, input bit q);
    int v;
    v = (q && e < i) ? e : i;
    return 10 * ((v > mm) ? mm : v);
  endfunction

  // Apply a reference and queue the saturated result
  task automatic drive(input int r, input bit ie);
    int lf;
    int lr;
    int o;
    bit f;
    lf = lim(fi, fe, fq);
    lr = lim(ri, re, rq);
    o = r;
    f = 1'b0;
    if (r > lf) begin
      o = lf;
      f = 1'b1;
    end else if (-r > lr) begin
      o = -lr;
      f = 1'b1;
    end
    torque_ref <= 16'(r);
    repeat (3) @(posedge ref_clk);
    tq_q.push_back({ie, f, 16'(o)});
    smp <= 1'b1;
    @(posedge ref_clk);
    smp <= 1'b0;
  endtask

  // Monitor: pops the oldest note when a result appears
  always @(posedge ref_clk) begin
    if (avs_read && avs_waitrequest === 1'b0 && rd_q.size() > 0) begin
      check("readdata", avs_readdata, rd_q.pop_front());
    end
    if (smp && tq_q.size() > 0) begin
      check("torque", 32'({irq, torque_limited_flag, torque_out}),
            32'(tq_q.pop_front()));
    end
  end

  // Watchdog
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_fail++;
    wrap_up();
  end

  //////////////////////////////
  // Main sequence
  initial begin
    seed = 28;
    n_fail = 0;
    n_checks = 0;
    rst_b = 1'b0;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    fwd_map = 4'h1;
    rev_map = 4'h2;
    torque_ref = 16'h0000;
    fwd_on = 1'b0;
    rev_on = 1'b0;
    aux_on = 1'b0;
    smp = 1'b0;
    fi = 800;
    ri = 800;
    fe = 100;
    re = 100;
    mm = 300;
    repeat (5) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk);
    rd(TLS_OFS_FWD_INT, 32'h320);
    rd(TLS_OFS_REV_INT, 32'h320);
    rd(TLS_OFS_FWD_EXT, 32'h064);
    rd(TLS_OFS_REV_EXT, 32'h064);
    rd(TLS_OFS_MOTOR_MAX, 32'h12C);
    rd(5'h02, 32'h0);
    bus(1'b1, TLS_OFS_IRQ_MASK, 32'h0);
    drive(3000, 1'b0);
    drive(3001, 1'b0);
    drive(-3001, 1'b0);
    wr(TLS_OFS_MOTOR_MAX, 800);
    drive(8001, 1'b0);
    wr(TLS_OFS_FWD_INT, 0);
    drive(1, 1'b0);
    wr(TLS_OFS_FWD_INT, 800);
    drive(0, 1'b0);
    fwd_map <= 4'h5;
    aux_on <= 1'b1;
    fq = 1'b1;
    repeat (8) @(posedge ref_clk);
    rd(TLS_OFS_STATUS, 32'h8);
    drive(1500, 1'b0);
    drive(0, 1'b0);
    fwd_map <= 4'h1;
    aux_on <= 1'b0;
    req(1'b0, 1'b0);
    // Clipped setting raises, masks and clears an interrupt
    bus(1'b1, TLS_OFS_IRQ_STAT, 32'h7);
    bus(1'b1, TLS_OFS_IRQ_MASK, 32'h4);
    wr(TLS_OFS_FWD_EXT, 1023);
    drive(0, 1'b1);
    rd(TLS_OFS_IRQ_STAT, 32'h4);
    rd(TLS_OFS_FWD_EXT, 32'h320);
    bus(1'b1, TLS_OFS_IRQ_MASK, 32'h0);
    drive(0, 1'b0);
    bus(1'b1, TLS_OFS_IRQ_MASK, 32'h4);
    bus(1'b1, TLS_OFS_IRQ_STAT, 32'h4);
    drive(0, 1'b0);
    rd(TLS_OFS_IRQ_STAT, 32'h0);
    bus(1'b1, TLS_OFS_IRQ_MASK, 32'h0);
    repeat (40) begin
      wr(TLS_OFS_FWD_INT, $random(seed) & 32'h3FF);
      wr(TLS_OFS_REV_INT, $random(seed) & 32'h3FF);
      wr(TLS_OFS_FWD_EXT, $random(seed) & 32'h3FF);
      wr(TLS_OFS_REV_EXT, $random(seed) & 32'h3FF);
      wr(TLS_OFS_MOTOR_MAX, ($random(seed) & 32'h1FF) + 32'd200);
      req(1'($random(seed)), 1'($random(seed)));
      drive($random(seed) % 9000, 1'b0);
    end
    wrap_up();
  end
endmodule
